// ---- logic/cfd_pkg.sv ----
package cfd_pkg;

  // ****************************************
  // Register map, byte addresses.
  // ****************************************
  localparam int            ADDR_W    = 10;
  localparam logic [9:0]    OFS_CTRL  = 10'h000;
  localparam logic [9:0]    OFS_ACK   = 10'h004;
  localparam logic [9:0]    OFS_FCNT  = 10'h008;
  localparam logic [9:0]    OFS_STAT  = 10'h00c;
  localparam logic [9:0]    OFS_WORD0 = 10'h080;
  localparam logic [9:0]    OFS_ID    = 10'h084;
  localparam logic [9:0]    OFS_PL    = 10'h088;
  localparam logic [9:0]    OFS_PH    = 10'h08c;
  localparam logic [9:0]    OFS_TAB   = 10'h0e0;

  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int            CTRL_EN_BIT  = 0;
  localparam int            CTRL_FMT_LSB = 1;
  localparam int            STAT_FD_BIT  = 4;
  localparam int            STD_ID_LSB   = 18;
  localparam logic [6:0]    TAB_FIRST    = 7'd4;
  localparam logic [6:0]    TAB_DEF      = 7'd8;
  localparam logic [6:0]    TAB_MAX      = 7'd104;
  localparam int            MAX_BYTES    = 8;
  localparam int            FIFO_DEPTH   = 4;
  localparam int            ENTRY_W      = 106;

  // ****************************************
  // Filter layouts and scanner states.
  // ****************************************
  typedef enum logic [1:0] {
    FMT_A = 2'b00,
    FMT_B = 2'b01,
    FMT_C = 2'b10,
    FMT_X = 2'b11
  } cfd_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_PUSH = 2'b10
  } cfd_state_t;

endpackage

// ---- logic/cfd_rx_queue.sv ----

// ****************************************
// Small FIFO between scanner and output stage.
// ****************************************
module cfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,   // System clock.
  input  wire logic             sys_rst,    // Synchronous reset.
  input  wire logic             flush,      // Empties the FIFO.
  input  wire logic             in_valid,   // Write request.
  output logic                  in_ready,   // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,    // Word written.
  output logic                  out_valid,  // Word available.
  input  wire logic             out_ready,  // Word taken.
  output logic [WIDTH-1:0]      out_data,   // Oldest word.
  output logic [$clog2(DEPTH):0] level      // Words held.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic             do_wr;
  logic             do_rd;

  // Handshakes and flags come straight from the counter; in_ready is also held low during flush.
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign level     = cnt_reg;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // Storage is written only on an accepted word.
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth, which is a power of two.
  always_ff @(posedge core_clk) begin
    if (sys_rst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ****************************************
// Receive queue with identifier filter table.
// ****************************************
module cfd_rx_queue
  import cfd_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              core_clk,    // System clock, 100 MHz.
  input  wire logic              sys_rst,     // Synchronous reset.
  input  wire logic [ADDR_W-1:0] reg_addr,    // Register byte address.
  input  wire logic [31:0]       reg_wdata,   // Write data.
  input  wire logic              reg_wr,      // Write strobe.
  input  wire logic              reg_rd,      // Read strobe.
  output logic [31:0]            reg_rdata,   // Read data, one cycle later.
  input  wire logic              frame_valid, // Received frame offered.
  output logic                   frame_ready, // Frame taken this cycle.
  input  wire logic              frame_ext,   // Extended identifier.
  input  wire logic              frame_rtr,   // Remote frame.
  input  wire logic              frame_fd,    // Flexible data rate frame.
  input  wire logic [3:0]        frame_dlc,   // Data length code.
  input  wire logic [28:0]       frame_id,    // Identifier, right aligned.
  input  wire logic [63:0]       frame_data   // Byte n in bits 8n+7:8n.
);

  // ****************************************
  // Decoding and matching functions.
  // ****************************************

  // Table hit: aligned word inside the full TAB_MAX element table.
  function automatic logic tab_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_TAB;
    return (a >= OFS_TAB) && (a[1:0] == 2'b00) && (d[8:2] < TAB_MAX) && !d[9];
  endfunction

  function automatic logic [6:0] tab_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_TAB;
    return d[8:2];
  endfunction

  // Byte mask that keeps only the bytes the length code covers.
  function automatic logic [63:0] keep_mask(input logic [3:0] data_length_code);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < MAX_BYTES; i++) begin
      if (i < int'(data_length_code)) begin
        m[8*i +: 8] = 8'hff;
      end
    end
    return m;
  endfunction

  // One element against one frame in the selected layout.
  function automatic logic elem_match(input logic [31:0] w, input logic [1:0] fmt,
                                      input logic ext, input logic rtr,
                                      input logic [28:0] id);
    logic        hit;
    logic [15:0] hw;
    hit = 1'b0;
    case (fmt)
      FMT_A: begin
        hit = (w[31] == rtr) && (w[30] == ext) &&
              (ext ? (w[29:1] == id) : (w[29:19] == id[28:18]));
      end
      FMT_B: begin
        for (int h = 0; h < 2; h++) begin
          hw = w[16*h +: 16];
          if ((hw[15] == rtr) && (hw[14] == ext) &&
              (ext ? (hw[13:0] == id[28:15]) : (hw[13:3] == id[28:18]))) begin
            hit = 1'b1;
          end
        end
      end
      FMT_C: begin
        for (int b = 0; b < 4; b++) begin
          if (w[8*b +: 8] == id[28:21]) begin
            hit = 1'b1;
          end
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ****************************************
  // Registers and state.
  // ****************************************
  logic [31:0]   tab_mem [0:TAB_MAX-1];
  logic          en_reg;
  logic [1:0]    fmt_sel_reg;
  logic [6:0]    fcnt_reg;
  logic          fd_drop_reg;
  cfd_state_t    st_reg;
  logic [6:0]    scan_idx_reg;
  logic [6:0]    hit_idx_reg;
  logic [28:0]   cap_id_reg;
  logic          cap_ext_reg;
  logic          cap_rtr_reg;
  logic [3:0]    cap_dlc_reg;
  logic [63:0]   cap_data_reg;
  logic          out_valid_reg;
  logic [6:0]    out_idx_reg;
  logic          out_ext_reg;
  logic          out_rtr_reg;
  logic [3:0]    out_dlc_reg;
  logic [28:0]   out_id_reg;
  logic [63:0]   out_data_reg;
  logic          take;
  logic          ack_wr;
  logic          scan_hit;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [ENTRY_W-1:0] fifo_out;
  logic [$clog2(DEPTH):0] fifo_level;

  assign take   = frame_valid && frame_ready;
  assign ack_wr = reg_wr && (reg_addr == OFS_ACK) && reg_wdata[0];
  assign scan_hit = elem_match(tab_mem[scan_idx_reg], fmt_sel_reg, cap_ext_reg,
                               cap_rtr_reg, cap_id_reg);

  // Control word: enable and the one format select for the whole table.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      en_reg      <= 1'b0;
      fmt_sel_reg <= FMT_A;
    end else if (reg_wr && (reg_addr == OFS_CTRL)) begin
      en_reg      <= reg_wdata[CTRL_EN_BIT];
      fmt_sel_reg <= reg_wdata[CTRL_FMT_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fcnt_reg <= TAB_DEF;
    end else if (reg_wr && (reg_addr == OFS_FCNT)) begin
      if (reg_wdata < 32'(TAB_DEF)) begin
        fcnt_reg <= TAB_DEF;
      end else if (reg_wdata > 32'(TAB_MAX)) begin
        fcnt_reg <= TAB_MAX;
      end else begin
        fcnt_reg <= reg_wdata[6:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reg_wr && tab_hit(reg_addr)) begin
      tab_mem[tab_index(reg_addr)] <= reg_wdata;
    end
  end

  // Dropped flexible rate frame flag; a new drop wins over a clear.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fd_drop_reg <= 1'b0;
    end else if (take && frame_fd) begin
      fd_drop_reg <= 1'b1;
    end else if (reg_wr && (reg_addr == OFS_STAT) && reg_wdata[STAT_FD_BIT]) begin
      fd_drop_reg <= 1'b0;
    end
  end

  // ****************************************
  // Frame capture and filter scan.
  // ****************************************

  // Capture registers load on every accepted frame.
  always_ff @(posedge core_clk) begin
    if (take) begin
      cap_id_reg   <= frame_ext ? frame_id : {frame_id[10:0], 18'h00000};
      cap_ext_reg  <= frame_ext;
      cap_rtr_reg  <= frame_rtr;
      cap_dlc_reg  <= frame_dlc;
      cap_data_reg <= frame_data & keep_mask(frame_dlc);
    end
  end

  // Scanner walks the table one element per cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg       <= ST_IDLE;
      frame_ready  <= 1'b1;
      scan_idx_reg <= '0;
      hit_idx_reg  <= '0;
    end else if (!en_reg && (st_reg != ST_IDLE)) begin
      st_reg      <= ST_IDLE;
      frame_ready <= 1'b1;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (take && en_reg && !frame_fd) begin
            st_reg       <= ST_SCAN;
            frame_ready  <= 1'b0;
            scan_idx_reg <= '0;
          end
        end
        ST_SCAN: begin
          if (scan_hit) begin
            st_reg      <= ST_PUSH;
            hit_idx_reg <= scan_idx_reg;
          end else if (scan_idx_reg == fcnt_reg - 1'b1) begin
            st_reg      <= ST_IDLE;
            frame_ready <= 1'b1;
          end else begin
            scan_idx_reg <= scan_idx_reg + 1'b1;
          end
        end
        ST_PUSH: begin
          if (fifo_in_ready) begin
            st_reg      <= ST_IDLE;
            frame_ready <= 1'b1;
          end
        end
        default: begin
          st_reg      <= ST_IDLE;
          frame_ready <= 1'b1;
        end
      endcase
    end
  end

  cfd_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .flush     (!en_reg),
    .in_valid  (st_reg == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   ({hit_idx_reg, cap_ext_reg, cap_rtr_reg, cap_dlc_reg,
                 cap_id_reg, cap_data_reg}),
    .out_valid (fifo_out_valid),
    .out_ready (!out_valid_reg),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // ****************************************
  // Output descriptor and register reads.
  // ****************************************

  always_ff @(posedge core_clk) begin
    if (sys_rst || !en_reg) begin
      out_valid_reg <= 1'b0;
    end else if (out_valid_reg) begin
      out_valid_reg <= !ack_wr;
    end else if (fifo_out_valid) begin
      out_valid_reg <= 1'b1;
    end
  end

  // Output words load from the FIFO head when the stage is free.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_idx_reg  <= '0;
      out_ext_reg  <= 1'b0;
      out_rtr_reg  <= 1'b0;
      out_dlc_reg  <= '0;
      out_id_reg   <= '0;
      out_data_reg <= '0;
    end else if (!out_valid_reg && fifo_out_valid) begin
      {out_idx_reg, out_ext_reg, out_rtr_reg, out_dlc_reg,
       out_id_reg, out_data_reg} <= fifo_out;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (tab_hit(reg_addr)) begin
        reg_rdata <= tab_mem[tab_index(reg_addr)];
      end else begin
        case (reg_addr)
          OFS_CTRL:  reg_rdata <= {29'h0, fmt_sel_reg, en_reg};
          OFS_FCNT:  reg_rdata <= {25'h0, fcnt_reg};
          OFS_STAT:  reg_rdata <= {27'h0, fd_drop_reg, 3'(fifo_level), out_valid_reg};
          OFS_WORD0: reg_rdata <= {2'b00, out_idx_reg + TAB_FIRST, 1'b0, out_ext_reg,
                                   out_rtr_reg, out_dlc_reg, 16'h0000};
          OFS_ID:    reg_rdata <= {3'b000, out_id_reg};
          OFS_PL:    reg_rdata <= {out_data_reg[7:0], out_data_reg[15:8],
                                   out_data_reg[23:16], out_data_reg[31:24]};
          OFS_PH:    reg_rdata <= {out_data_reg[39:32], out_data_reg[47:40],
                                   out_data_reg[55:48], out_data_reg[63:56]};
          default:   reg_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  property p_std_low_zero;
    @(posedge core_clk) disable iff (sys_rst)
    (out_valid_reg && !out_ext_reg) |-> (out_id_reg[STD_ID_LSB-1:0] == '0);
  endproperty
  a_std_low_zero: assert property (p_std_low_zero)
    else $error("standard frame has nonzero low identifier bits");

  property p_ext_id;
    @(posedge core_clk) disable iff (sys_rst)
    (take && frame_ext) |=> (cap_id_reg == $past(frame_id));
  endproperty
  a_ext_id: assert property (p_ext_id)
    else $error("extended identifier not captured whole");

  property p_pl_order;
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == OFS_PL && !tab_hit(reg_addr))
      |=> (reg_rdata[31:24] == $past(out_data_reg[7:0]))
       && (reg_rdata[7:0] == $past(out_data_reg[31:24]));
  endproperty
  a_pl_order: assert property (p_pl_order)
    else $error("payload low word byte order wrong");

  property p_ph_order;
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == OFS_PH)
      |=> (reg_rdata[31:24] == $past(out_data_reg[39:32]))
       && (reg_rdata[7:0] == $past(out_data_reg[63:56]));
  endproperty
  a_ph_order: assert property (p_ph_order)
    else $error("payload high word byte order wrong");

  property p_dlc_mask;
    @(posedge core_clk) disable iff (sys_rst)
    (st_reg == ST_SCAN) |-> ((cap_data_reg & ~keep_mask(cap_dlc_reg)) == '0);
  endproperty
  a_dlc_mask: assert property (p_dlc_mask)
    else $error("bytes beyond length code kept");

  property p_fd_drop;
    @(posedge core_clk) disable iff (sys_rst)
    (take && frame_fd) |=> (st_reg == ST_IDLE) ##1 (st_reg == ST_IDLE);
  endproperty
  a_fd_drop: assert property (p_fd_drop)
    else $error("flexible rate frame entered the scan");

  property p_tab_write;
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == OFS_TAB + 10'h004) |=> (tab_mem[1] == $past(reg_wdata));
  endproperty
  a_tab_write: assert property (p_tab_write)
    else $error("second table element not at next word");

  property p_disabled;
    @(posedge core_clk) disable iff (sys_rst)
    !en_reg |=> !out_valid_reg && (fifo_level == '0);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("queue holds a frame while disabled");

  property p_fcnt_range;
    @(posedge core_clk) disable iff (sys_rst)
    (fcnt_reg >= TAB_DEF) && (fcnt_reg <= TAB_MAX);
  endproperty
  a_fcnt_range: assert property (p_fcnt_range)
    else $error("table length out of range");

  property p_read_quiet;
    @(posedge core_clk) disable iff (sys_rst)
    (out_valid_reg && en_reg && !ack_wr) |=> out_valid_reg && $stable(out_id_reg);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("output changed without acknowledge");

endmodule

// ---- tb/cfd_node_model.sv ----
// ****************************************
// Bus node that offers received frames to the queue.
// ****************************************
module cfd_node_model (
  input  wire logic        core_clk,    // System clock.
  input  wire logic        slow,        // Adds idle cycles after each frame.
  input  wire logic        frame_ready, // Frame taken by the block.
  output logic             frame_valid, // Frame offered.
  output logic             frame_ext,   // Extended identifier.
  output logic             frame_rtr,   // Remote frame.
  output logic             frame_fd,    // Flexible data rate frame.
  output logic [3:0]       frame_dlc,   // Data length code.
  output logic [28:0]      frame_id,    // Identifier.
  output logic [63:0]      frame_data   // Payload bytes.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [99:0] pend_q[$];
  logic [99:0] cur;
  int          gap;

  // Queues one frame as {fd, ext, rtr, dlc, id, data}.
  task automatic push(input logic [99:0] f);
    pend_q.push_back(f);
  endtask

  // Holds each frame until taken, then scrambles the released lines.
  initial begin
    frame_valid = 1'b0;
    {frame_fd, frame_ext, frame_rtr, frame_dlc, frame_id, frame_data} = '0;
    cur = '0;
    gap = 0;
    forever begin
      @(posedge core_clk);
      if (frame_valid && frame_ready) begin
        frame_valid <= 1'b0;
        {frame_fd, frame_ext, frame_rtr, frame_dlc, frame_id, frame_data} <= ~cur;
        gap = slow ? 3 : 0;
      end else if (gap > 0) begin
        gap--;
      end else if (!frame_valid && pend_q.size() > 0) begin
        cur = pend_q.pop_front();
        {frame_fd, frame_ext, frame_rtr, frame_dlc, frame_id, frame_data} <= cur;
        frame_valid <= 1'b1;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cfd_pkg::*;

  logic        core_clk, sys_rst, reg_wr, reg_rd, slow;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rword;
  logic        frame_valid, frame_ready, frame_ext, frame_rtr, frame_fd;
  logic [3:0]  frame_dlc;
  logic [28:0] frame_id;
  logic [63:0] frame_data;
  int          err_total, check_count;
  localparam logic [28:0] EXT_ID = 29'h0abcdef1;
  localparam logic [63:0] DATA_A = 64'h8877665544332211;

  cfd_rx_queue #(.DEPTH(4)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_ext(frame_ext), .frame_rtr(frame_rtr), .frame_fd(frame_fd),
    .frame_dlc(frame_dlc), .frame_id(frame_id), .frame_data(frame_data));

  cfd_node_model node_u (.core_clk(core_clk), .slow(slow), .frame_ready(frame_ready),
    .frame_valid(frame_valid), .frame_ext(frame_ext), .frame_rtr(frame_rtr),
    .frame_fd(frame_fd), .frame_dlc(frame_dlc), .frame_id(frame_id),
    .frame_data(frame_data));

  // ****************************************
  // Bus access and comparison tasks.
  // ****************************************
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    cmp(d, exp);
  endtask

  // Polls the output valid flag under a bounded count.
  task automatic wait_out(input logic want);
    logic [31:0] d;
    int n;
    n = 0;
    rd(OFS_STAT, d);
    while (d[0] !== want && n < 60) begin
      rd(OFS_STAT, d);
      n++;
    end
    cmp({31'h0, d[0]}, {31'h0, want});
  endtask

  task automatic send(input logic ext, input logic fd, input logic [3:0] data_length_code,
                      input logic [28:0] id, input logic [63:0] data);
    node_u.push({fd, ext, 1'b0, data_length_code, id, data});
  endtask

  // Packs four payload bytes, first byte on top, bytes past the length as zero.
  function automatic logic [31:0] pl(logic [63:0] d, logic [3:0] data_length_code, int w);
    int n;
    logic [31:0] r;
    n = (data_length_code > 8) ? 8 : int'(data_length_code);
    r = '0;
    for (int k = 4 * w; k < 4 * w + 4; k++) begin
      r = {r[23:0], (k < n) ? d[8*k +: 8] : 8'h00};
    end
    return r;
  endfunction

  task automatic expect_frame(input logic [8:0] el, input logic ext, input logic [3:0] data_length_code,
                              input logic [28:0] id, input logic [63:0] data);
    chk(OFS_WORD0, {el, 1'b0, ext, 1'b0, data_length_code, 16'h0});
    chk(OFS_ID, ext ? {3'h0, id} : {3'h0, id[10:0], 18'h0});
    chk(OFS_PL, pl(data, data_length_code, 0));
    chk(OFS_PH, pl(data, data_length_code, 1));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Free running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("watchdog expired");
    results();
  end

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    {sys_rst, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = {1'b1, 3'b0, 10'h0, 32'h0};
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk(OFS_CTRL, 32'h0);
    chk(OFS_STAT, 32'h0);
    chk(OFS_FCNT, 32'h8);
    wr(OFS_FCNT, 32'd200);
    chk(OFS_FCNT, 32'd104);
    wr(OFS_FCNT, 32'd3);
    chk(OFS_FCNT, 32'd8);
    for (int i = 2; i < 8; i++) wr(OFS_TAB + 10'(4 * i), 32'hffffffff);
    wr(OFS_TAB, {2'b00, 11'h123, 19'h0});
    wr(OFS_TAB + 10'h4, {2'b01, EXT_ID, 1'b0});
    wr(OFS_TAB + 10'h19c, 32'h5a5a0103);
    chk(OFS_TAB + 10'h19c, 32'h5a5a0103);
    chk(OFS_TAB + 10'h4, {2'b01, EXT_ID, 1'b0});
    chk(10'h280, 32'h0);
    $display("test registers done");
    send(1'b0, 1'b0, 4'd8, 29'h123, DATA_A);
    repeat (30) @(posedge core_clk);
    chk(OFS_STAT, 32'h0);
    wr(OFS_CTRL, 32'h1);
    send(1'b0, 1'b0, 4'd8, 29'h123, DATA_A);
    wait_out(1'b1);
    expect_frame(9'd4, 1'b0, 4'd8, 29'h123, DATA_A);
    send(1'b1, 1'b0, 4'd3, EXT_ID, DATA_A);
    repeat (30) @(posedge core_clk);
    expect_frame(9'd4, 1'b0, 4'd8, 29'h123, DATA_A);
    wr(OFS_ACK, 32'h1);
    wait_out(1'b1);
    expect_frame(9'd5, 1'b1, 4'd3, EXT_ID, DATA_A);
    wr(OFS_ACK, 32'h1);
    wait_out(1'b0);
    $display("test delivery done");
    send(1'b0, 1'b1, 4'd8, 29'h123, DATA_A);
    repeat (30) @(posedge core_clk);
    chk(OFS_STAT, 32'h10);
    wr(OFS_STAT, 32'h10);
    chk(OFS_STAT, 32'h0);
    $display("test fd drop done");
    for (int k = 0; k < 6; k++) send(1'b0, 1'b0, 4'd1, 29'h123, 64'(k + 1));
    repeat (150) @(posedge core_clk);
    chk(OFS_STAT, 32'h9);
    cmp({31'h0, frame_ready}, 32'h0);
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      wait_out(1'b1);
      chk(OFS_PL, {8'(k + 1), 24'h0});
      wr(OFS_ACK, 32'h1);
    end
    wait_out(1'b0);
    $display("test fill and drain done");
    // Software keeps one layout for the whole table at a time.
    for (int f = 1; f < 4; f++) begin
      wr(OFS_CTRL, {29'h0, 2'(f), 1'b1});
      wr(OFS_TAB, (f == 1) ? 32'hffff0918 : (f == 2) ? 32'h24ffffff : 32'h09180000);
      send(1'b0, 1'b0, 4'd2, 29'h123, DATA_A);
      repeat (40) @(posedge core_clk);
      if (f == 3) begin
        chk(OFS_STAT, 32'h0);
      end else begin
        wait_out(1'b1);
        expect_frame(9'd4, 1'b0, 4'd2, 29'h123, DATA_A);
        wr(OFS_ACK, 32'h1);
        wait_out(1'b0);
      end
    end
    $display("test formats done");
    results();
  end
endmodule
